// ===== hdl/usart_pkg.sv
// constants and register layout of the serial transmit and receive datapath
// Notes on behaviour
// - transmit enable hands the transmit pin to the transmitter as serial output
// - synchronous mode clocks the transmitter from the external bit clock pin
// - data write fills the buffer; it moves to shifter when idle or after stop
// - a loaded shifter sends one whole frame at the selected bit rate
// - unused high data bits are ignored for characters shorter than eight bits
// - nine-bit characters take bit eight from tx_bit8, set before the data write
// - tx_buf_empty is one when the buffer is empty, zero while it holds data
// - empty interrupt requested while tx_buf_empty and enabled; data write clears
// - tx_complete sets when the frame has left and the buffer is empty
// - tx_complete clears on interrupt service or on a written one
// - complete interrupt is requested while tx_complete is set and enabled
// - with parity enabled, parity goes after the last data bit, before stop
// - clearing transmit enable waits until buffer and shifter are empty
// - receive enable hands the receive pin to the receiver as serial input
// - synchronous mode samples received bits on the external bit clock
// - reception starts on a valid start bit, then samples each bit at rate
// - the receiver ignores any second stop bit
// - after the first stop bit the character moves to the receive buffer
// - unused high bits read as zero for characters shorter than eight bits
// - frame is low start, 5 to 9 data bits lsb first, parity, stop; idle high
// - parity is xor of data bits, inverted for odd parity
// - async bit period is 16 clocks times divider plus one, 8 at double speed
// - polarity zero changes data on rising edge, samples on falling; else reverse
package usart_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int DIV_W = 12;
    localparam logic [2:0] ADR_CTRL_A = 3'h0;
    localparam logic [2:0] ADR_CTRL_B = 3'h1;
    localparam logic [2:0] ADR_CTRL_C = 3'h2;
    localparam logic [2:0] ADR_BAUD_LO = 3'h3;
    localparam logic [2:0] ADR_BAUD_HI = 3'h4;
    localparam logic [2:0] ADR_DATA = 3'h5;
    // ctrl_status_a
    localparam int A_RX_COMPLETE = 7;
    localparam int A_TX_COMPLETE = 6;
    localparam int A_TX_BUF_EMPTY = 5;
    localparam int A_DOUBLE_SPEED = 1;
    // ctrl_status_b
    localparam int B_TX_COMPLETE_IRQ_EN = 6;
    localparam int B_TX_BUF_EMPTY_IRQ_EN = 5;
    localparam int B_RX_ENABLE = 4;
    localparam int B_TX_ENABLE = 3;
    localparam int B_CHAR_SIZE2 = 2;
    localparam int B_RX_BIT8 = 1;
    localparam int B_TX_BIT8 = 0;
    // ctrl_status_c
    localparam int C_SYNC_MODE = 6;
    localparam int C_PARITY_ENABLE = 5;
    localparam int C_PARITY_ODD_SEL = 4;
    localparam int C_STOP_BITS_SEL = 3;
    localparam int C_CHAR_SIZE_LO = 1;
    localparam int C_CLOCK_POLARITY = 0;
    localparam logic [2:0] CHAR_SIZE_RESET = 3'h3;
    localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
    localparam logic [3:0] OS_NORMAL = 4'h0F;
    localparam logic [3:0] OS_DOUBLE = 4'h07;
    localparam logic [DIV_W-1:0] BAUD_RESET = 12'h000;
endpackage

// ===== hdl/usart_bit_timer.sv
// bit rate and external clock edge generator for the serial datapath
`timescale 1ns/1ps
module usart_bit_timer #(
    parameter int DIV_W = usart_pkg::DIV_W
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [DIV_W-1:0] div,
    input wire logic double_speed,
    input wire logic sync_mode,
    input wire logic clock_polarity,
    input wire logic xck_pin,
    output logic os_tick,
    output logic tx_tick
);
    import usart_pkg::*;

    if (DIV_W < 1 || DIV_W > 16) begin : g_div_w_check
        $error("divider width out of range");
    end

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [3:0] sub;
        logic x1;
        logic x2;
        logic x3;
    } timer_type;

    timer_type st;
    timer_type next_st;
    logic rise;
    logic fall;

    assign rise = st.x2 & ~st.x3;
    assign fall = ~st.x2 & st.x3;

    always_comb begin
        // sync: data changes on one edge, samples on the other
        if (sync_mode) begin
            os_tick = clock_polarity ? rise : fall;
            tx_tick = clock_polarity ? fall : rise;
        end else begin
            os_tick = (st.cnt == '0);
            tx_tick = (st.cnt == '0) && (st.sub == 4'h0);
        end
    end

    always_comb begin
        next_st = st;
        next_st.x1 = xck_pin;
        next_st.x2 = st.x1;
        next_st.x3 = st.x2;
        if (st.cnt == '0) begin
            next_st.cnt = div;
            if (st.sub == 4'h0) begin
                next_st.sub = double_speed ? OS_DOUBLE : OS_NORMAL;
            end else begin
                next_st.sub = st.sub - 4'h1;
            end
        end else begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ===== hdl/usart_tx_rx_datapath.sv
// serial transmitter and receiver front end with register port
`timescale 1ns/1ps
module usart_tx_rx_datapath (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [usart_pkg::ADDR_W-1:0] ADDR,
    input wire logic [usart_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [usart_pkg::DATA_W-1:0] RDATA,
    output logic TXD_OUT,
    output logic TXD_OE,
    input wire logic RXD_IN,
    output logic RX_OWN,
    input wire logic XCK_IN,
    output logic IRQ_TX_EMPTY,
    output logic IRQ_TX_DONE,
    input wire logic IRQ_TX_DONE_ACK
);
    import usart_pkg::*;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_type;

    typedef struct packed {
        logic double_speed;
        logic tx_complete;
        logic tx_complete_irq_en;
        logic tx_buf_empty_irq_en;
        logic rx_enable;
        logic tx_enable;
        logic [2:0] char_size;
        logic tx_bit8;
        logic sync_mode;
        logic parity_enable;
        logic parity_odd_sel;
        logic stop_bits_sel;
        logic clock_polarity;
        logic [DIV_W-1:0] baud_div;
        logic [8:0] tx_buf;
        logic tx_full;
        logic [12:0] tx_shift;
        logic [3:0] tx_left;
        logic tx_active;
        logic rx_sync1;
        logic rx_sync2;
        rx_state_type rx_state;
        logic [3:0] rx_cnt;
        logic [3:0] rx_bits;
        logic [10:0] rx_shift;
        logic [8:0] rx_buf;
        logic rx_full;
        logic [DATA_W-1:0] rdata;
    } state_type;

    state_type st;
    state_type next_st;
    logic os_tick;
    logic tx_tick;
    logic [3:0] n_data;
    logic [3:0] rx_total;
    logic [3:0] os_full;
    logic [3:0] os_half;
    logic rx_bit;
    logic [10:0] rx_aligned;
    logic [12:0] frame;
    logic [3:0] frame_len;

    // number of data bits for a character size code
    function automatic logic [3:0] data_bits(input logic [2:0] cs);
        if (cs == CHAR_SIZE_NINE) begin
            data_bits = 4'h9;
        end else begin
            data_bits = 4'h5 + {2'b00, cs[1:0]};
        end
    endfunction

    // keeps only the data bits in use
    function automatic logic [8:0] data_mask(input logic [3:0] n);
        data_mask = 9'h1FF >> (4'h9 - n);
    endfunction

    usart_bit_timer #(
        .DIV_W(DIV_W)
    ) timer (
        .CLK(CLK),
        .RST(RST),
        .div(st.baud_div),
        .double_speed(st.double_speed),
        .sync_mode(st.sync_mode),
        .clock_polarity(st.clock_polarity),
        .xck_pin(XCK_IN),
        .os_tick(os_tick),
        .tx_tick(tx_tick)
    );

    assign n_data = data_bits(st.char_size);
    assign rx_total = n_data + {3'b000, st.parity_enable} + 4'h1;
    assign os_full = st.double_speed ? OS_DOUBLE : OS_NORMAL;
    assign os_half = os_full >> 1;
    assign rx_bit = st.rx_sync2;
    assign rx_aligned = {rx_bit, st.rx_shift[10:1]} >> (4'hB - rx_total);

    // frame image lsb first, padded with idle ones
    always_comb begin
        logic [8:0] d;
        logic [3:0] pos;
        d = st.tx_buf & data_mask(n_data);
        pos = n_data + 4'h1;
        frame = 13'h1FFF;
        frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n_data) begin
                frame[i + 1] = d[i];
            end
        end
        if (st.parity_enable) begin
            frame[pos] = (^d) ^ st.parity_odd_sel;
        end
        frame_len = pos + {3'b000, st.parity_enable} + 4'h1
            + {3'b000, st.stop_bits_sel};
    end

    always_comb begin
        next_st = st;
        next_st.rx_sync1 = RXD_IN;
        next_st.rx_sync2 = st.rx_sync1;

        // transmitter: shift, reload straight after the last stop bit
        if (tx_tick) begin
            if (st.tx_active && st.tx_left > 4'h1) begin
                next_st.tx_shift = {1'b1, st.tx_shift[12:1]};
                next_st.tx_left = st.tx_left - 4'h1;
            end else if (st.tx_full) begin
                next_st.tx_shift = frame;
                next_st.tx_left = frame_len;
                next_st.tx_active = 1'b1;
                next_st.tx_full = 1'b0;
            end else begin
                next_st.tx_active = 1'b0;
            end
        end

        // receiver
        if (!st.rx_enable) begin
            next_st.rx_state = RX_IDLE;
            next_st.rx_full = 1'b0;
        end else if (os_tick) begin
            unique case (st.rx_state)
                RX_IDLE: begin
                    next_st.rx_cnt = 4'h0;
                    next_st.rx_bits = 4'h0;
                    if (!rx_bit) begin
                        next_st.rx_state = st.sync_mode ? RX_BITS : RX_START;
                    end
                end
                RX_START: begin
                    next_st.rx_cnt = st.rx_cnt + 4'h1;
                    if (st.rx_cnt == os_half - 4'h1) begin
                        next_st.rx_cnt = 4'h0;
                        next_st.rx_state = rx_bit ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    next_st.rx_cnt = st.rx_cnt + 4'h1;
                    if (st.sync_mode || st.rx_cnt == os_full) begin
                        next_st.rx_cnt = 4'h0;
                        next_st.rx_shift = {rx_bit, st.rx_shift[10:1]};
                        next_st.rx_bits = st.rx_bits + 4'h1;
                        if (st.rx_bits + 4'h1 == rx_total) begin
                            // first stop bit in: hand over the character
                            next_st.rx_buf = rx_aligned[8:0]
                                & data_mask(n_data);
                            next_st.rx_full = 1'b1;
                            next_st.rx_state = RX_IDLE;
                        end
                    end
                end
            endcase
        end

        // register writes
        if (IRQ_TX_DONE_ACK) begin
            next_st.tx_complete = 1'b0;
        end
        if (WR) begin
            unique case (ADDR)
                ADR_CTRL_A: begin
                    next_st.double_speed = WDATA[A_DOUBLE_SPEED];
                    if (WDATA[A_TX_COMPLETE]) begin
                        next_st.tx_complete = 1'b0;
                    end
                end
                ADR_CTRL_B: begin
                    next_st.tx_complete_irq_en = WDATA[B_TX_COMPLETE_IRQ_EN];
                    next_st.tx_buf_empty_irq_en = WDATA[B_TX_BUF_EMPTY_IRQ_EN];
                    next_st.rx_enable = WDATA[B_RX_ENABLE];
                    next_st.tx_enable = WDATA[B_TX_ENABLE];
                    next_st.char_size[2] = WDATA[B_CHAR_SIZE2];
                    next_st.tx_bit8 = WDATA[B_TX_BIT8];
                end
                ADR_CTRL_C: begin
                    next_st.sync_mode = WDATA[C_SYNC_MODE];
                    next_st.parity_enable = WDATA[C_PARITY_ENABLE];
                    next_st.parity_odd_sel = WDATA[C_PARITY_ODD_SEL];
                    next_st.stop_bits_sel = WDATA[C_STOP_BITS_SEL];
                    next_st.char_size[1:0] = WDATA[C_CHAR_SIZE_LO +: 2];
                    next_st.clock_polarity = WDATA[C_CLOCK_POLARITY];
                end
                ADR_BAUD_LO: begin
                    next_st.baud_div[7:0] = WDATA;
                end
                ADR_BAUD_HI: begin
                    next_st.baud_div[DIV_W-1:8] = WDATA[DIV_W-9:0];
                end
                ADR_DATA: begin
                    if (st.tx_enable) begin
                        next_st.tx_buf = {st.tx_bit8, WDATA};
                        next_st.tx_full = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // frame ended with nothing waiting: set wins over any clear
        if (tx_tick && st.tx_active && st.tx_left == 4'h1 && !st.tx_full) begin
            next_st.tx_complete = 1'b1;
        end

        // register reads, answered next cycle
        next_st.rdata = '0;
        if (RD) begin
            unique case (ADDR)
                ADR_CTRL_A: begin
                    next_st.rdata[A_RX_COMPLETE] = st.rx_full;
                    next_st.rdata[A_TX_COMPLETE] = st.tx_complete;
                    next_st.rdata[A_TX_BUF_EMPTY] = !st.tx_full;
                    next_st.rdata[A_DOUBLE_SPEED] = st.double_speed;
                end
                ADR_CTRL_B: begin
                    next_st.rdata[B_TX_COMPLETE_IRQ_EN] = st.tx_complete_irq_en;
                    next_st.rdata[B_TX_BUF_EMPTY_IRQ_EN] = st.tx_buf_empty_irq_en;
                    next_st.rdata[B_RX_ENABLE] = st.rx_enable;
                    next_st.rdata[B_TX_ENABLE] = st.tx_enable;
                    next_st.rdata[B_CHAR_SIZE2] = st.char_size[2];
                    next_st.rdata[B_RX_BIT8] = st.rx_buf[8];
                    next_st.rdata[B_TX_BIT8] = st.tx_bit8;
                end
                ADR_CTRL_C: begin
                    next_st.rdata[C_SYNC_MODE] = st.sync_mode;
                    next_st.rdata[C_PARITY_ENABLE] = st.parity_enable;
                    next_st.rdata[C_PARITY_ODD_SEL] = st.parity_odd_sel;
                    next_st.rdata[C_STOP_BITS_SEL] = st.stop_bits_sel;
                    next_st.rdata[C_CHAR_SIZE_LO +: 2] = st.char_size[1:0];
                    next_st.rdata[C_CLOCK_POLARITY] = st.clock_polarity;
                end
                ADR_BAUD_LO: begin
                    next_st.rdata = st.baud_div[7:0];
                end
                ADR_BAUD_HI: begin
                    next_st.rdata[DIV_W-9:0] = st.baud_div[DIV_W-1:8];
                end
                ADR_DATA: begin
                    next_st.rdata = st.rx_buf[7:0];
                    if (!(os_tick && st.rx_state == RX_BITS
                          && next_st.rx_state == RX_IDLE)) begin
                        next_st.rx_full = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.char_size <= CHAR_SIZE_RESET;
            st.baud_div <= BAUD_RESET;
            st.rx_sync1 <= 1'b1;
            st.rx_sync2 <= 1'b1;
            st.rx_state <= RX_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA = st.rdata;
    assign TXD_OUT = st.tx_active ? st.tx_shift[0] : 1'b1;
    assign TXD_OE = st.tx_enable | st.tx_active | st.tx_full;
    assign RX_OWN = st.rx_enable;
    assign IRQ_TX_EMPTY = st.tx_buf_empty_irq_en & !st.tx_full;
    assign IRQ_TX_DONE = st.tx_complete_irq_en & st.tx_complete;

    a_pin_owned: assert property (
        @(posedge CLK) disable iff (RST)
        st.tx_enable |-> TXD_OE)
        else $error("transmit pin not driven while enabled");

    a_disable_waits: assert property (
        @(posedge CLK) disable iff (RST)
        (st.tx_full || st.tx_active) |-> TXD_OE)
        else $error("transmit pin released with data pending");

    a_write_fills: assert property (
        @(posedge CLK) disable iff (RST)
        (WR && ADDR == ADR_DATA && st.tx_enable) |=> st.tx_full)
        else $error("data write did not fill the buffer");

    a_start_low: assert property (
        @(posedge CLK) disable iff (RST)
        $rose(st.tx_active) |-> !TXD_OUT
            && (!st.tx_full || $past(WR && ADDR == ADR_DATA)))
        else $error("frame did not open with a low start bit");

    a_idle_high: assert property (
        @(posedge CLK) disable iff (RST)
        !st.tx_active |-> TXD_OUT)
        else $error("line not idle high");

    a_done_sets: assert property (
        @(posedge CLK) disable iff (RST)
        (tx_tick && st.tx_active && st.tx_left == 4'h1 && !st.tx_full)
        |=> st.tx_complete && !st.tx_active)
        else $error("transmit complete not flagged");

    a_ack_clears: assert property (
        @(posedge CLK) disable iff (RST)
        (IRQ_TX_DONE_ACK && !tx_tick) |=> !st.tx_complete)
        else $error("transmit complete not cleared");

    a_char_stored: assert property (
        @(posedge CLK) disable iff (RST)
        (st.rx_enable && os_tick && st.rx_state == RX_BITS
         && (st.sync_mode || st.rx_cnt == os_full)
         && st.rx_bits + 4'h1 == rx_total)
        |=> st.rx_full && st.rx_state == RX_IDLE)
        else $error("received character not stored");

    a_read_masked: assert property (
        @(posedge CLK) disable iff (RST)
        ($past(RD) && $past(ADDR) == ADR_DATA && st.char_size == 3'h0)
        |-> RDATA[7:5] == 3'h0)
        else $error("unused received bits not zero");
endmodule

// ===== tb/serial_partner.sv
// model of the remote serial device on the transmit and receive lines
`timescale 1ns/1ps
module serial_partner #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    logic [15:0] got_q[$];
    int cap_len = 11;
    int bit_clks = BIT_CLKS;

    initial begin
        rxd = 1'b1;
    end

    // one frame per falling edge of the idle line, sampled mid-bit
    initial begin : capture
        logic [15:0] f;
        forever begin
            @(negedge txd);
            f = '0;
            repeat (bit_clks / 2) @(posedge clk);
            for (int i = 0; i < cap_len; i++) begin
                if (i > 0) begin
                    repeat (bit_clks) @(posedge clk);
                end
                f[i] = txd;
            end
            got_q.push_back(f);
        end
    end

    // bits go out lsb first; the line is pulled back high afterwards
    task automatic send_frame(input logic [15:0] bits, input int len);
        for (int i = 0; i < len; i++) begin
            rxd <= bits[i];
            repeat (bit_clks) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask
endmodule

// ===== tb/testbench.sv
// self-checking testbench of the serial transmit and receive datapath
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    bad_count++; $display("BAD t=%0t got %h exp %h", $time, got, exp); \
    end end
module testbench;
    import usart_pkg::*;
    logic CLK, RST, WR, RD, RXD_IN, XCK_IN, IRQ_TX_DONE_ACK;
    logic [ADDR_W-1:0] ADDR;
    logic [DATA_W-1:0] WDATA, RDATA, q;
    logic TXD_OUT, TXD_OE, RX_OWN, IRQ_TX_EMPTY, IRQ_TX_DONE, txd_line;
    logic [15:0] e1, e2, g;
    logic [31:0] seed = 32'hFB79;
    int bad_count = 0, n_checks = 0, cycles = 0, len, k;

    // released transmit pin is pulled high
    assign txd_line = TXD_OE ? TXD_OUT : 1'b1;

    usart_tx_rx_datapath DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TXD_OUT(TXD_OUT),
        .TXD_OE(TXD_OE), .RXD_IN(RXD_IN), .RX_OWN(RX_OWN), .XCK_IN(XCK_IN),
        .IRQ_TX_EMPTY(IRQ_TX_EMPTY), .IRQ_TX_DONE(IRQ_TX_DONE),
        .IRQ_TX_DONE_ACK(IRQ_TX_DONE_ACK));
    serial_partner #(.BIT_CLKS(16)) PARTNER (.clk(CLK), .txd(txd_line),
        .rxd(RXD_IN));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // start, data lsb first, optional parity, first stop bit
    function automatic logic [15:0] frame_bits(input logic [8:0] d,
            input int n, input logic pe, input logic po, output int ln);
        logic [15:0] f;
        logic p;
        f = '0;
        p = po;
        for (int i = 0; i < n; i++) begin
            f[1+i] = d[i];
            p ^= d[i];
        end
        ln = n + 1;
        if (pe) begin
            f[ln] = p;
            ln++;
        end
        f[ln] = 1'b1;
        ln++;
        return f;
    endfunction

    function automatic logic [7:0] cc(input int n, input logic pe, po);
        logic [2:0] cs;
        cs = (n == 9) ? CHAR_SIZE_NINE : 3'(n - 5);
        return {2'h0, pe, po, 1'b0, cs[1:0], 1'b0};
    endfunction

    function automatic logic [7:0] cb(input logic te, input int n,
            input logic b8);
        return {5'h0E, (n == 9), 1'b0, b8} | {4'h0, te, 3'h0};
    endfunction

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
        @(posedge CLK);
    endtask

    task automatic wait_cap();
        k = 0;
        while (PARTNER.got_q.size() == 0 && k < 600) begin
            @(posedge CLK);
            k++;
        end
        g = PARTNER.got_q.size() ? PARTNER.got_q.pop_front() : 16'hFFFF;
    endtask

    task automatic tx_one(input logic [8:0] d, input int n, input logic pe,
            input logic po);
        e1 = frame_bits(d, n, pe, po, len);
        PARTNER.cap_len = len;
        wr(ADR_CTRL_C, cc(n, pe, po));
        wr(ADR_CTRL_B, cb(1'b1, n, d[8]));
        wr(ADR_DATA, d[7:0]);
        wait_cap();
        `CHECK(g, e1)
        repeat (16) @(posedge CLK);
    endtask

    task automatic rx_one(input logic [8:0] d, input int n, input logic pe,
            input logic po);
        e1 = frame_bits(d, n, pe, po, len);
        e1[len] = 1'b1;
        wr(ADR_CTRL_C, cc(n, pe, po) | 8'h08);
        wr(ADR_CTRL_B, cb(1'b1, n, 1'b0));
        PARTNER.send_frame(e1, len + 1);
        k = 0;
        q = '0;
        while (!q[A_RX_COMPLETE] && k < 200) begin
            rd(ADR_CTRL_A, q);
            k++;
        end
        rd(ADR_CTRL_B, q);
        `CHECK(q[B_RX_BIT8], d[8] & (n == 9))
        rd(ADR_DATA, q);
        `CHECK(q, d[7:0] & 8'((9'h100 >> (8 - n)) - 1))
        rd(ADR_CTRL_A, q);
        `CHECK(q[A_RX_COMPLETE], 1'b0)
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        {RST, WR, RD, XCK_IN, IRQ_TX_DONE_ACK} = 5'h10;
        ADDR = '0;
        WDATA = '0;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        #1 `CHECK({TXD_OE, TXD_OUT, RX_OWN}, 3'h2)
        rd(ADR_CTRL_A, q);
        `CHECK(q, 8'h20)
        rd(ADR_CTRL_C, q);
        `CHECK(q, 8'h06)
        rd(3'h6, q);
        `CHECK(q, 8'h00)
        wr(ADR_BAUD_LO, 8'h00);
        wr(ADR_CTRL_B, cb(1'b1, 8, 1'b0));
        #1 `CHECK({TXD_OE, RX_OWN, IRQ_TX_EMPTY}, 3'h7)
        for (int n = 5; n <= 9; n++) begin
            for (int m = 0; m < 3; m++) begin
                seed = xs(seed);
                tx_one(seed[8:0], n, m != 0, m == 2);
                rx_one(seed[24:16], n, m != 0, m == 2);
            end
        end
        // double speed with a divider of two: 24 clocks per bit
        wr(ADR_BAUD_LO, 8'h02);
        wr(ADR_CTRL_A, 8'h02);
        PARTNER.bit_clks = 24;
        seed = xs(seed);
        tx_one(seed[8:0], 8, 1'b1, 1'b0);
        PARTNER.bit_clks = 16;
        wr(ADR_BAUD_LO, 8'h00);
        // two characters back to back, then flag clearing
        PARTNER.cap_len = 10;
        wr(ADR_CTRL_C, cc(8, 1'b0, 1'b0));
        wr(ADR_CTRL_A, 8'h40);
        rd(ADR_CTRL_A, q);
        `CHECK(q[A_TX_COMPLETE], 1'b0)
        seed = xs(seed);
        wr(ADR_DATA, seed[7:0]);
        k = 0;
        q = '0;
        while (!q[A_TX_BUF_EMPTY] && k < 20) begin
            rd(ADR_CTRL_A, q);
            k++;
        end
        `CHECK(q[A_TX_BUF_EMPTY], 1'b1)
        wr(ADR_DATA, seed[15:8]);
        #1 `CHECK(IRQ_TX_EMPTY, 1'b0)
        rd(ADR_CTRL_A, q);
        `CHECK(q[A_TX_BUF_EMPTY], 1'b0)
        k = 0;
        while (IRQ_TX_DONE !== 1'b1 && k < 800) begin
            @(posedge CLK);
            k++;
        end
        `CHECK(IRQ_TX_DONE, 1'b1)
        `CHECK(PARTNER.got_q.size(), 2)
        e1 = frame_bits({1'b0, seed[7:0]}, 8, 1'b0, 1'b0, len);
        e2 = frame_bits({1'b0, seed[15:8]}, 8, 1'b0, 1'b0, len);
        wait_cap();
        `CHECK(g, e1)
        wait_cap();
        `CHECK(g, e2)
        IRQ_TX_DONE_ACK <= 1'b1;
        @(posedge CLK);
        IRQ_TX_DONE_ACK <= 1'b0;
        @(posedge CLK);
        #1 `CHECK(IRQ_TX_DONE, 1'b0)
        // disable while the character still waits in the buffer
        wr(ADR_DATA, 8'hA5);
        wr(ADR_CTRL_B, cb(1'b0, 8, 1'b0));
        #1 `CHECK(TXD_OE, 1'b1)
        wait_cap();
        `CHECK(g, frame_bits(9'h0A5, 8, 1'b0, 1'b0, len))
        repeat (32) @(posedge CLK);
        #1 `CHECK(TXD_OE, 1'b0)
        // synchronous transmit: data changes after rising, sampled at falling
        wr(ADR_CTRL_B, cb(1'b1, 8, 1'b0));
        wr(ADR_CTRL_C, cc(8, 1'b0, 1'b0) | 8'h40);
        seed = xs(seed);
        wr(ADR_DATA, seed[7:0]);
        g = '0;
        for (int i = 0; i < 10; i++) begin
            XCK_IN <= 1'b1;
            repeat (6) @(posedge CLK);
            XCK_IN <= 1'b0;
            g[i] = txd_line;
            repeat (6) @(posedge CLK);
        end
        `CHECK(g, frame_bits({1'b0, seed[7:0]}, 8, 1'b0, 1'b0, len))
        give_verdict();
    end
endmodule
